// ---- design/spd_defines.svh ----
// constants of the serial programmed divider core: word layout, reset values, timing
// assumes inclusion by the package and the design modules; definitions only
//
// What this block does
// [RULE_01] reference divider is a 10-bit counter, ratios 2 to 1023, from oscillator input
// [RULE_02] reference divider counts reference input edges; input at most 40 MHz
// [RULE_03] feedback divider is 15 bits: 5-bit swallow plus 10-bit main, 992..32767
// [RULE_04] 32/33 prescaler clocks swallow and main counters; swallow picks modulus
// [RULE_05] detector compares both divider outputs; each at most 10 MHz
// [RULE_06] polarity picks whether lagging feedback gives pump-up or pump-down
// [RULE_07] pump sources high on up, sinks low on down, otherwise high impedance
// [RULE_08] pump activity feeds back to detector, forcing minimum-width pulses, no dead zone
// [RULE_09] each serial clock rise shifts data into 18-bit register, msb first
// [RULE_10] shift bits 17..1 are data, bit 0 is address, shifted last
// [RULE_11] load strobe rise copies data field into the latch the address picks
// [RULE_12] address 1 selects reference word, address 0 selects feedback word
// [RULE_13] chip enable low powers down and floats pump regardless of power-down bit
// [RULE_14] power-down bit disables dividers, oscillator block, floats rf and reference inputs
// [RULE_15] any power-down forces pump and detector inactive, high impedance
// [RULE_16] power-down resets counters; restart keeps both dividers aligned
// [RULE_17] serial shifting and loading keep working in every power-down mode
// [RULE_18] pump high-impedance bit floats pump and detector; clear means normal; code still drives the pump in test mode with the bit set
// [RULE_19] polarity 1 means positive vco slope, 0 means negative
// [RULE_20] test mode drives divider output on pump: reference if polarity 0, else feedback
// [RULE_21] feedback ratio is 32 times main plus swallow; 33 for swallowed cycles
// [RULE_22] host shifts 18 bits with strobe low, then pulses strobe once
// [RULE_23] divider words change only at a load strobe rise
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

// serial word layout
`define SPD_SHIFT_W        18
`define SPD_WORD_W         17
`define SPD_ADDR_BIT       0
`define SPD_FB_WORD_ADDR   1'h0
`define SPD_REF_WORD_ADDR  1'h1

// reference word fields
`define SPD_REF_CNT_MSB    9
`define SPD_REF_CNT_LSB    0
`define SPD_PUMP_HIZ_BIT   10
`define SPD_POL_BIT        11
`define SPD_TEST_BIT       13

// feedback word fields
`define SPD_MAIN_MSB       16
`define SPD_MAIN_LSB       7
`define SPD_SWAL_MSB       6
`define SPD_SWAL_LSB       2
`define SPD_PD_BIT         0

// reset values: powered down, pump floating
`define SPD_FB_WORD_RST    17'h00001
`define SPD_REF_WORD_RST   17'h00400

// prescaler moduli
`define SPD_PRESC_LOW      6'h20
`define SPD_PRESC_HIGH     6'h21

// timing
`define SPD_CLK_NS         8
`define SPD_PUMP_MIN_NS    16
`define SPD_PUMP_MIN_CYC   ((`SPD_PUMP_MIN_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS)
`define SPD_REF_MAX_MHZ    40
`define SPD_PFD_MAX_MHZ    10

`endif

// ---- design/spd_div_counter.sv ----
// reloading down counter used by the dividers and the prescaler
// assumes one clock; clr and en come from logic on the same clock
`timescale 1ns/10ps

module spd_div_counter
  import spd_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] load_val,
  output logic              tc,
  output logic [W-1:0]      count
);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  ////////////////////////////////////////////////////////////////////////////
  // next count: reload at one, so a load of r gives r enables per period
  always_comb begin
    nxt_count = count_ff;
    if (clr) begin
      nxt_count = load_val;                  // RULE_16
    end else if (en) begin
      if (count_ff <= W'(1)) begin
        nxt_count = load_val;
      end else begin
        nxt_count = count_ff - W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign tc    = en && !clr && (count_ff <= W'(1));
  assign count = count_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  clear_reload_a: assert property (@(posedge clk) disable iff (rst) // RULE_16
    clr |=> count_ff == $past(load_val))
    else $error("counter did not restart from its load value");

endmodule

// ---- design/spd_pkg.sv ----
// types shared by the divider core modules
// assumes the constants header sits beside it
`include "spd_defines.svh"

package spd_pkg;

  typedef logic [`SPD_WORD_W-1:0]  spd_word_t;
  typedef logic [`SPD_SHIFT_W-1:0] spd_shift_t;
  typedef logic [2:0]              spd_width_t;

  // detector state: which pump requests are pending
  typedef enum logic [1:0] {
    SPD_PFD_IDLE,
    SPD_PFD_UP,
    SPD_PFD_DOWN,
    SPD_PFD_BOTH
  } spd_pfd_state_t;

endpackage

// ---- design/spd_pll_core.sv ----
// digital core of the integer-n synthesizer: serial port, dividers, detector, pump pin
// assumes all pins are asynchronous to CLK and are slower than a quarter of its rate
`timescale 1ns/10ps
`include "spd_defines.svh"

module spd_pll_core
  import spd_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic SER_CLK,
  input  wire logic SER_DATA,
  input  wire logic LOAD_STROBE,
  input  wire logic CHIP_ENABLE,
  input  wire logic REFERENCE_INPUT,
  input  wire logic RF_INPUT,
  output logic      PUMP_OUTPUT_O,
  output logic      PUMP_OUTPUT_OE_N,
  output logic      REFERENCE_INPUT_HIZ,
  output logic      RF_INPUT_HIZ
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [5:0] sync3_ff;
  logic [5:0] pin_rise;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= {RF_INPUT, REFERENCE_INPUT, CHIP_ENABLE, LOAD_STROBE, SER_DATA, SER_CLK};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign pin_rise = sync2_ff & ~sync3_ff;

  logic sclk_rise;
  logic data_s;
  logic le_rise;
  logic ce_s;
  logic ref_rise;
  logic rf_rise;

  assign sclk_rise = pin_rise[0];
  assign data_s    = sync2_ff[1];
  assign le_rise   = pin_rise[2];
  assign ce_s      = sync2_ff[3];
  assign ref_rise  = pin_rise[4];
  assign rf_rise   = pin_rise[5];

  ////////////////////////////////////////////////////////////////////////////
  // serial shift register and the two latched words, live in every power state
  spd_shift_t shift_ff;
  spd_shift_t nxt_shift;
  spd_word_t  ref_word_ff;
  spd_word_t  nxt_ref_word;
  spd_word_t  fb_word_ff;
  spd_word_t  nxt_fb_word;

  always_comb begin
    nxt_shift    = shift_ff;
    nxt_ref_word = ref_word_ff;
    nxt_fb_word  = fb_word_ff;
    if (sclk_rise) begin
      nxt_shift = {shift_ff[`SPD_SHIFT_W-2:0], data_s};          // RULE_09 RULE_17
    end
    if (le_rise) begin                                             // RULE_11 RULE_23
      if (shift_ff[`SPD_ADDR_BIT] == `SPD_REF_WORD_ADDR) begin     // RULE_12
        nxt_ref_word = shift_ff[`SPD_SHIFT_W-1:1];                 // RULE_10
      end else begin
        nxt_fb_word = shift_ff[`SPD_SHIFT_W-1:1];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift_ff    <= '0;
      ref_word_ff <= `SPD_REF_WORD_RST;
      fb_word_ff  <= `SPD_FB_WORD_RST;
    end else begin
      shift_ff    <= nxt_shift;
      ref_word_ff <= nxt_ref_word;
      fb_word_ff  <= nxt_fb_word;
    end
  end

  // field decode
  logic [9:0] ref_ratio;
  logic [9:0] main_ratio;
  logic [4:0] swal_ratio;
  logic       pump_hiz;
  logic       polarity;
  logic       test_mode;
  logic       active;

  assign ref_ratio  = ref_word_ff[`SPD_REF_CNT_MSB:`SPD_REF_CNT_LSB];
  assign pump_hiz   = ref_word_ff[`SPD_PUMP_HIZ_BIT];
  assign polarity   = ref_word_ff[`SPD_POL_BIT];
  assign test_mode  = ref_word_ff[`SPD_TEST_BIT];
  assign main_ratio = fb_word_ff[`SPD_MAIN_MSB:`SPD_MAIN_LSB];
  assign swal_ratio = fb_word_ff[`SPD_SWAL_MSB:`SPD_SWAL_LSB];
  // chip enable low wins over the bit; either one stops the whole loop
  assign active     = ce_s && !fb_word_ff[`SPD_PD_BIT];           // RULE_13 RULE_14

  ////////////////////////////////////////////////////////////////////////////
  // reference divider on reference input edges, held in reset while powered down
  logic ref_tc;

  spd_div_counter #(.W(10)) u_ref_div (                           // RULE_01
    .clk      (CLK),
    .rst      (RST),
    .clr      (!active),                                           // RULE_16
    .en       (ref_rise),                                          // RULE_02
    .load_val (ref_ratio),
    .tc       (ref_tc),
    .count    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // feedback divider: prescaler, swallow and main counters
  logic [4:0] swal_ff;
  logic [4:0] nxt_swal;
  logic [5:0] presc_load;
  logic       presc_tc;
  logic       main_tc;

  // swallow counts down once per prescaler period, reloads at the main terminal
  always_comb begin
    nxt_swal = swal_ff;
    if (!active || main_tc) begin
      nxt_swal = swal_ratio;                                       // RULE_03 RULE_16
    end else if (presc_tc && (swal_ff != 5'h00)) begin
      nxt_swal = swal_ff - 5'h01;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      swal_ff <= '0;
    end else begin
      swal_ff <= nxt_swal;
    end
  end

  // the next period runs at 33 while swallows remain, giving 32*main + swallow
  assign presc_load = (nxt_swal != 5'h00) ? `SPD_PRESC_HIGH : `SPD_PRESC_LOW; // RULE_04 RULE_21

  spd_div_counter #(.W(6)) u_presc (
    .clk      (CLK),
    .rst      (RST),
    .clr      (!active),
    .en       (rf_rise),
    .load_val (presc_load),
    .tc       (presc_tc),
    .count    ()
  );

  spd_div_counter #(.W(10)) u_main_div (                          // RULE_03
    .clk      (CLK),
    .rst      (RST),
    .clr      (!active),
    .en       (presc_tc),
    .load_val (main_ratio),
    .tc       (main_tc),
    .count    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // divider output pulses, one cycle each, shared by detector and test mode
  logic ref_out_ff;
  logic fb_out_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ref_out_ff <= 1'b0;
      fb_out_ff  <= 1'b0;
    end else begin
      ref_out_ff <= ref_tc;
      fb_out_ff  <= main_tc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase/frequency detector; pump activity time is fed back so that
  // requests reset only after a minimum width, which removes the dead zone
  spd_pfd_state_t pfd_ff;
  spd_pfd_state_t nxt_pfd;
  spd_width_t     width_ff;
  spd_width_t     nxt_width;
  logic           up_evt;
  logic           dn_evt;
  logic           width_done;
  logic           pfd_on;

  // reference leading means feedback lags: pump-up for a positive slope
  assign up_evt     = polarity ? ref_out_ff : fb_out_ff;          // RULE_05 RULE_06 RULE_19
  assign dn_evt     = polarity ? fb_out_ff : ref_out_ff;
  assign width_done = width_ff >= spd_width_t'(`SPD_PUMP_MIN_CYC - 1); // RULE_08
  assign pfd_on     = active && !pump_hiz && !test_mode;           // RULE_15 RULE_18

  always_comb begin
    nxt_pfd = pfd_ff;
    unique case (pfd_ff)
      SPD_PFD_IDLE: begin
        if (up_evt && dn_evt) begin
          nxt_pfd = SPD_PFD_BOTH;
        end else if (up_evt) begin
          nxt_pfd = SPD_PFD_UP;
        end else if (dn_evt) begin
          nxt_pfd = SPD_PFD_DOWN;
        end
      end
      SPD_PFD_UP: begin
        if (dn_evt) begin
          nxt_pfd = width_done ? SPD_PFD_IDLE : SPD_PFD_BOTH;
        end
      end
      SPD_PFD_DOWN: begin
        if (up_evt) begin
          nxt_pfd = width_done ? SPD_PFD_IDLE : SPD_PFD_BOTH;
        end
      end
      SPD_PFD_BOTH: begin
        if (width_done) begin
          nxt_pfd = SPD_PFD_IDLE;
        end
      end
    endcase
    if (!pfd_on) begin
      nxt_pfd = SPD_PFD_IDLE;                                      // RULE_15
    end
    nxt_width = '0;
    if (nxt_pfd != SPD_PFD_IDLE && pfd_ff != SPD_PFD_IDLE && !width_done) begin
      nxt_width = width_ff + spd_width_t'(1);
    end else if (nxt_pfd != SPD_PFD_IDLE && pfd_ff != SPD_PFD_IDLE) begin
      nxt_width = width_ff;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pfd_ff   <= SPD_PFD_IDLE;
      width_ff <= '0;
    end else begin
      pfd_ff   <= nxt_pfd;
      width_ff <= nxt_width;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pump pin and input bias status
  logic pump_o;
  logic pump_oe_n;
  logic pump_o_ff;
  logic pump_oe_n_ff;
  logic ref_hiz_ff;
  logic rf_hiz_ff;

  always_comb begin
    pump_o    = 1'b0;
    pump_oe_n = 1'b1;                                              // RULE_13 RULE_15
    if (active && test_mode) begin
      pump_oe_n = 1'b0;                                            // RULE_20
      pump_o    = polarity ? fb_out_ff : ref_out_ff;
    end else if (pfd_on && pfd_ff == SPD_PFD_UP) begin
      pump_oe_n = 1'b0;                                            // RULE_07
      pump_o    = 1'b1;
    end else if (pfd_on && pfd_ff == SPD_PFD_DOWN) begin
      pump_oe_n = 1'b0;
      pump_o    = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pump_o_ff    <= 1'b0;
      pump_oe_n_ff <= 1'b1;
      ref_hiz_ff   <= 1'b1;
      rf_hiz_ff    <= 1'b1;
    end else begin
      pump_o_ff    <= pump_o;
      pump_oe_n_ff <= pump_oe_n;
      ref_hiz_ff   <= !active;                                     // RULE_14
      rf_hiz_ff    <= !active;
    end
  end

  assign PUMP_OUTPUT_O       = pump_o_ff;
  assign PUMP_OUTPUT_OE_N    = pump_oe_n_ff;
  assign REFERENCE_INPUT_HIZ = ref_hiz_ff;
  assign RF_INPUT_HIZ        = rf_hiz_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  shift_in_a: assert property (sclk_rise |=>                      // RULE_09
    shift_ff == {$past(shift_ff[`SPD_SHIFT_W-2:0]), $past(data_s)})
    else $error("serial bit not shifted in at the lsb");
  load_ref_a: assert property (le_rise && shift_ff[0] |=>         // RULE_12
    ref_word_ff == $past(shift_ff[`SPD_SHIFT_W-1:1]) && $stable(fb_word_ff))
    else $error("reference word not loaded on address one");
  load_fb_a: assert property (le_rise && !shift_ff[0] |=>         // RULE_11
    fb_word_ff == $past(shift_ff[`SPD_SHIFT_W-1:1]) && $stable(ref_word_ff))
    else $error("feedback word not loaded on address zero");
  words_hold_a: assert property (!le_rise |=>                     // RULE_23
    $stable(ref_word_ff) && $stable(fb_word_ff))
    else $error("divider word changed without a strobe");
  powerdown_float_a: assert property (!active |=> pump_oe_n_ff && rf_hiz_ff) // RULE_13
    else $error("pump driven or input biased while powered down");
  tristate_bit_a: assert property (active && pump_hiz && !test_mode |=> // RULE_18
    pump_oe_n_ff && pfd_ff == SPD_PFD_IDLE)
    else $error("pump not floating with its high impedance bit set");
  pump_level_a: assert property (pfd_on && pfd_ff == SPD_PFD_DOWN |=> // RULE_07
    !pump_oe_n_ff && !pump_o_ff)
    else $error("pump-down did not sink the pump pin");
  min_width_a: assert property ($rose(pfd_ff != SPD_PFD_IDLE) && pfd_on |=> // RULE_08
    pfd_ff != SPD_PFD_IDLE)
    else $error("pump request shorter than the minimum width");
  polarity_a: assert property (pfd_on && polarity && ref_out_ff && !fb_out_ff && // RULE_06
    pfd_ff == SPD_PFD_IDLE |=> pfd_ff == SPD_PFD_UP)
    else $error("leading reference did not request pump-up");
  test_mode_a: assert property (active && test_mode |=>           // RULE_20
    !pump_oe_n_ff && pump_o_ff == $past(polarity ? fb_out_ff : ref_out_ff))
    else $error("test mode did not show the selected divider");

  load_ref_c: cover property (le_rise && shift_ff[0]);
  pump_up_c: cover property (pfd_ff == SPD_PFD_UP ##1 pfd_ff == SPD_PFD_BOTH);
  test_out_c: cover property (active && test_mode && fb_out_ff);
  wake_c: cover property (!active ##1 active);

endmodule

// ---- dv/spd_host_model.sv ----
// host model: shifts 18-bit words msb first, then pulses the load strobe
// assumes clk is the core clock; pins change just after its rising edge
`timescale 1ns/10ps

module spd_host_model (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);

  // pins start low; serial clock stands still between frames, data rests at the inverse of bit 0
  initial begin
    ser_clk     = 1'h0;
    ser_data    = 1'h0;
    load_strobe = 1'h0;
  end

  // one frame: 18 bits with strobe low, then a single strobe pulse
  task automatic send_word(input logic [17:0] w);
    for (int i = 17; i >= 0; i--) begin
      @(posedge clk);
      ser_data <= w[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'h1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'h0;
      repeat (4) @(posedge clk);
      ser_data <= ~w[i];               // hold over: no stale level left on the line
    end
    repeat (4) @(posedge clk);
    load_strobe <= 1'h1;
    repeat (4) @(posedge clk);
    load_strobe <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

endmodule

// ---- dv/tb.sv ----
// self-checking bench: serial programming, dividers, pump pin, power control
// assumes the host model drives the serial pins; divider inputs toggle every 4 cycles
`timescale 1ns/10ps

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb;
  localparam int IN_PER = 8;      // cycles per divider input period
  localparam int LIMIT  = 90000;  // cycle ceiling for the whole run

  logic       clk;
  logic       rst;
  logic       ce;
  logic       src_in;
  logic [1:0] div_cnt;
  logic       ser_clk;
  logic       ser_data;
  logic       load_strobe;
  logic       pump_o;
  logic       pump_oe_n;
  logic       ref_hiz;
  logic       rf_hiz;
  logic       last_o;
  int         error_cnt;
  int         cmp_count;
  int         cyc_cnt;

  ////////////////////////////////////////
  spd_host_model i_host (
    .clk         (clk),
    .ser_clk     (ser_clk),
    .ser_data    (ser_data),
    .load_strobe (load_strobe)
  );

  spd_pll_core i_dut (
    .CLK                 (clk),
    .RST                 (rst),
    .SER_CLK             (ser_clk),
    .SER_DATA            (ser_data),
    .LOAD_STROBE         (load_strobe),
    .CHIP_ENABLE         (ce),
    .REFERENCE_INPUT     (src_in),
    .RF_INPUT            (src_in),
    .PUMP_OUTPUT_O       (pump_o),
    .PUMP_OUTPUT_OE_N    (pump_oe_n),
    .REFERENCE_INPUT_HIZ (ref_hiz),
    .RF_INPUT_HIZ        (rf_hiz)
  );

  ////////////////////////////////////////
  // 125 mhz core clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // divider inputs toggle every 4 cycles; last pump level kept for edge search
  always @(posedge clk) begin
    last_o <= pump_o;
    if (rst) begin
      div_cnt <= 2'h0;
      src_in  <= 1'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      if (div_cnt == 2'h3) begin
        src_in <= ~src_in;
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // reference word: test, reserved 0, polarity, pump floating, ratio, address 1
  task automatic send_ref(input logic [9:0] ratio, input logic hiz, input logic pol, input logic test);
    i_host.send_word({3'h0, test, 1'h0, pol, hiz, ratio, 1'h1});
    repeat (10) @(posedge clk);
  endtask

  // feedback word: main, swallow, unused, power-down, address 0
  task automatic send_fb(input logic [9:0] main, input logic [4:0] sw, input logic pd);
    i_host.send_word({main, sw, 1'h0, pd, 1'h0});
    repeat (10) @(posedge clk);
  endtask

  // cycles between the 2nd and 3rd rising edge of the pump level
  task automatic pulse_gap(output int gap);
    int t0;
    int edges;
    t0    = 0;
    edges = 0;
    gap   = -1;
    for (int n = 0; n < 30000 && gap < 0; n++) begin
      @(posedge clk);
      if (pump_o === 1'h1 && last_o === 1'h0) begin
        edges++;
        if (edges == 2) t0 = n;
        if (edges == 3) gap = n - t0;
      end
    end
  endtask

  // cycles within a window in which the pump pin was not floating
  task automatic count_driven(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      @(posedge clk);
      if (pump_oe_n !== 1'h1) n++;
    end
  endtask

  ////////////////////////////////////////
  // after reset: powered down, pump floating, inputs de-biased
  task automatic t_reset();
    @(posedge clk);
    `CHK(pump_oe_n, 1'h1);
    `CHK(ref_hiz, 1'h1);
    `CHK(rf_hiz, 1'h1);
  endtask

  // leave power-down while the pump is held floating by its bit
  task automatic t_power_up();
    int n;
    send_ref(10'h002, 1'h1, 1'h0, 1'h0);
    send_fb(10'h01f, 5'h05, 1'h0);
    `CHK(ref_hiz, 1'h0);
    `CHK(rf_hiz, 1'h0);
    count_driven(200, n);
    `CHK(n, 0);
  endtask

  // test mode, polarity 0: reference divider on the pump, both ratio extremes
  task automatic t_test_ref();
    int gap;
    send_ref(10'h002, 1'h1, 1'h0, 1'h1);
    pulse_gap(gap);
    `CHK(gap, 2 * IN_PER);
    send_ref(10'h3ff, 1'h1, 1'h0, 1'h1);
    pulse_gap(gap);
    `CHK(gap, 1023 * IN_PER);
  endtask

  // test mode, polarity 1: feedback divider kept across reference writes
  task automatic t_test_fb();
    int gap;
    send_ref(10'h002, 1'h1, 1'h1, 1'h1);
    pulse_gap(gap);
    `CHK(gap, (32 * 31 + 5) * IN_PER);
  endtask

  // reference leading: polarity 1 pumps up, polarity 0 pumps down
  task automatic t_polarity();
    int n;
    for (int p = 1; p >= 0; p--) begin
      send_fb(10'h3ff, 5'h00, 1'h1);
      send_ref(10'h002, 1'h0, p[0], 1'h0);
      send_fb(10'h3ff, 5'h00, 1'h0);
      n = 0;
      while (pump_oe_n !== 1'h0 && n < 200) begin
        @(posedge clk);
        n++;
      end
      `CHK(pump_o, p[0]);
      repeat (2) @(posedge clk);
      `CHK(pump_oe_n, 1'h0);
    end
  endtask

  // chip enable low floats a driving pump; loading still works meanwhile
  task automatic t_chip_enable();
    int gap;
    @(posedge clk);
    ce <= 1'h0;
    repeat (6) @(posedge clk);
    `CHK(pump_oe_n, 1'h1);
    `CHK(rf_hiz, 1'h1);
    send_ref(10'h002, 1'h1, 1'h0, 1'h1);
    send_fb(10'h01f, 5'h05, 1'h0);
    `CHK(pump_oe_n, 1'h1);
    @(posedge clk);
    ce <= 1'h1;
    pulse_gap(gap);
    `CHK(gap, 2 * IN_PER);
  endtask

  // power-down bit stops test-mode output and de-biases both inputs
  task automatic t_pd_bit();
    int n;
    send_fb(10'h01f, 5'h05, 1'h1);
    `CHK(ref_hiz, 1'h1);
    `CHK(rf_hiz, 1'h1);
    count_driven(200, n);
    `CHK(n, 0);
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    rst       = 1'h1;
    ce        = 1'h1;
    error_cnt = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_power_up();
    t_test_ref();
    t_test_fb();
    t_polarity();
    t_chip_enable();
    t_pd_bit();
    wrap_up();
  end

endmodule
